//--- core/sbp_bus_port.sv
module sbp_bus_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Command from the core
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sbp_pkg::sbp_cmd_t cmd_op,
  input wire logic [7:0] cmd_wdata,
  // Read data to the core
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Bus pins
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe_n,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  // Test inputs
  input wire logic test_input_zero,
  input wire logic test_input_one,
  input wire logic ext_int_n,
  output logic test_zero_q,
  output logic test_one_q,
  output logic ext_int_n_q,
  // Single step and RAM guard
  input wire logic step_pause_n,
  input wire logic ram_req,
  output logic ram_grant,
  output logic instr_run
);

  typedef enum logic [1:0] {
    SBP_IDLE,
    SBP_WAIT,
    SBP_STROBE,
    SBP_DONE
  } sbp_state_t;

  logic state_en;
  logic cycle_en;
  logic [2:0] state_idx;
  sbp_state_t st_q;
  sbp_pkg::sbp_cmd_t op_q;
  logic [7:0] out_q;
  logic latched_q;
  logic [7:0] bus_s1_q;
  logic [7:0] bus_s2_q;
  logic [2:0] tst_s1_q;
  logic [2:0] tst_s2_q;
  logic [1:0] ss_s_q;
  logic halted_q;
  logic push_valid;
  logic push_ready;
  logic [7:0] cap_q;
  logic cap_v_q;
  logic is_rd;
  logic is_wr;
  logic stb_end;

  // ==========================================================================
  // Machine timing
  sbp_timebase u_tb (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .state_en(state_en),
    .state_idx(state_idx),
    .cycle_en(cycle_en)
  );

  assign ale = (state_idx == sbp_pkg::ALE_STATE) && !halted_q;

  // ==========================================================================
  // Synchronisers for pins
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
      tst_s1_q <= 3'h0;
      tst_s2_q <= 3'h0;
      ss_s_q <= 2'h3;
    end
    else
    begin
      bus_s1_q <= bus_in;
      bus_s2_q <= bus_s1_q;
      tst_s1_q <= {ext_int_n, test_input_one, test_input_zero};
      tst_s2_q <= tst_s1_q;
      ss_s_q <= {ss_s_q[0], step_pause_n};
    end
  end

  // Direct branch sampling without an accumulator load
  assign test_zero_q = tst_s2_q[0];
  assign test_one_q = tst_s2_q[1];
  assign ext_int_n_q = tst_s2_q[2];

  // ==========================================================================
  // Data RAM guard: reset stops every access
  assign ram_grant = rstn && ram_req;

  // ==========================================================================
  // Single step: halt at the end of a machine cycle in which the sequencer is idle while step is low
  // Enter and leave only on a cycle boundary so every ALE pulse stays whole;
  // a step pulse shorter than one machine cycle may therefore be missed
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      halted_q <= 1'b0;
    else if (cycle_en)
    begin
      if (ss_s_q[1])
        halted_q <= 1'b0;
      else if (st_q == SBP_IDLE)
        halted_q <= 1'b1;
    end
  end

  assign instr_run = !halted_q;

  // ==========================================================================
  // Transfer sequencer
  assign is_rd = (op_q == sbp_pkg::SBP_CMD_EXT_RD) || (op_q == sbp_pkg::SBP_CMD_STROBED_IN);
  assign is_wr = (op_q == sbp_pkg::SBP_CMD_EXT_WR) || (op_q == sbp_pkg::SBP_CMD_LATCH_OUT);
  assign stb_end = state_en && (state_idx == sbp_pkg::STB_END);
  // Refuse new commands while halted, busy, a capture waits, or a halt starts
  // now: a command taken on that edge would run with ALE already stopped
  assign cmd_ready = (st_q == SBP_IDLE) && !halted_q && !cap_v_q &&
                     !(cycle_en && !ss_s_q[1]);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= SBP_IDLE;
      op_q <= sbp_pkg::SBP_CMD_NONE;
    end
    else
    begin
      case (st_q)
        SBP_IDLE:
        begin
          if (cmd_valid && cmd_ready && cmd_op != sbp_pkg::SBP_CMD_NONE)
          begin
            op_q <= cmd_op;
            st_q <= SBP_WAIT;
          end
        end
        SBP_WAIT:
        begin
          if (state_en && state_idx == sbp_pkg::ALE_STATE)
            st_q <= SBP_STROBE;
        end
        SBP_STROBE:
        begin
          if (stb_end)
            st_q <= SBP_DONE;
        end
        SBP_DONE:
        begin
          st_q <= SBP_IDLE;
          op_q <= sbp_pkg::SBP_CMD_NONE;
        end
        default:
          st_q <= SBP_IDLE;
      endcase
    end
  end

  // Strobes low during the strobe window, also for static commands
  assign rd_n = !((st_q == SBP_STROBE) && is_rd);
  assign wr_n = !((st_q == SBP_STROBE) && is_wr);

  // ==========================================================================
  // Output latch
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      out_q <= sbp_pkg::BUS_RST;
    else if (cmd_valid && cmd_ready && (cmd_op == sbp_pkg::SBP_CMD_LATCH_OUT ||
             cmd_op == sbp_pkg::SBP_CMD_EXT_WR))
      out_q <= cmd_wdata;
  end

  // Static latch keeps driving until a read or an external move
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      latched_q <= 1'b0;
    else if (st_q == SBP_DONE)
      latched_q <= (op_q == sbp_pkg::SBP_CMD_LATCH_OUT);
    else if (cmd_valid && cmd_ready && cmd_op != sbp_pkg::SBP_CMD_NONE &&
             cmd_op != sbp_pkg::SBP_CMD_LATCH_OUT)
      latched_q <= 1'b0;
  end

  assign bus_out = out_q;
  // One enable for all eight lines: direction is per byte
  assign bus_oe_n = !(latched_q || (is_wr && st_q != SBP_IDLE));

  // ==========================================================================
  // Read capture at the strobe trailing edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cap_q <= 8'h00;
      cap_v_q <= 1'b0;
    end
    else if (stb_end && st_q == SBP_STROBE && is_rd)
    begin
      cap_q <= bus_s2_q;
      cap_v_q <= 1'b1;
    end
    else if (push_ready)
      cap_v_q <= 1'b0;
  end

  assign push_valid = cap_v_q;

  sbp_skid_buf #(
    .WIDTH(sbp_pkg::BUS_W)
  ) u_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(cap_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

endmodule : sbp_bus_port

//--- core/sbp_pkg.sv
package sbp_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned BUS_W = 8;

  // ==========================================================================
  // Timing: oscillator divided by three, then by five per machine cycle
  localparam int unsigned OSC_DIV = 3;
  localparam int unsigned CYC_DIV = 5;
  localparam logic [1:0] OSC_CNT_MAX = 2'h2;
  localparam logic [2:0] CYC_CNT_MAX = 3'h4;
  // Strobe low from state 1 to state 3 of a machine cycle
  localparam logic [2:0] STB_START = 3'h1;
  localparam logic [2:0] STB_END = 3'h3;
  localparam logic [2:0] ALE_STATE = 3'h0;
  localparam int unsigned RST_MIN_CYC = 5;

  // ==========================================================================
  // Commands
  typedef enum logic [2:0] {
    SBP_CMD_NONE,
    SBP_CMD_LATCH_OUT,
    SBP_CMD_STROBED_IN,
    SBP_CMD_EXT_WR,
    SBP_CMD_EXT_RD
  } sbp_cmd_t;

  localparam logic [7:0] BUS_RST = 8'h00;
  localparam int unsigned BUF_DEPTH = 2;

endpackage : sbp_pkg

//--- core/sbp_skid_buf.sv
module sbp_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Two entries: head and tail
  logic [WIDTH-1:0] ent0_q;
  logic [WIDTH-1:0] ent1_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = ent0_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= 2'h0;
    else if (push && !pop)
      cnt_q <= cnt_q + 2'h1;
    else if (pop && !push)
      cnt_q <= cnt_q - 2'h1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ent0_q <= '0;
      ent1_q <= '0;
    end
    else
    begin
      if (pop)
      begin
        ent0_q <= (cnt_q == 2'h2) ? ent1_q : in_data;
        if (push)
          ent1_q <= in_data;
      end
      else if (push)
      begin
        if (cnt_q == 2'h0)
          ent0_q <= in_data;
        else
          ent1_q <= in_data;
      end
    end
  end

endmodule : sbp_skid_buf

//--- core/sbp_timebase.sv
module sbp_timebase (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Enables
  output logic state_en,
  output logic [2:0] state_idx,
  output logic cycle_en
);

  logic [1:0] osc_cnt_q;
  logic [2:0] st_cnt_q;

  // ==========================================================================
  // Divide by three
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_cnt_q <= 2'h0;
    else if (osc_cnt_q == sbp_pkg::OSC_CNT_MAX)
      osc_cnt_q <= 2'h0;
    else
      osc_cnt_q <= osc_cnt_q + 2'h1;
  end

  assign state_en = (osc_cnt_q == sbp_pkg::OSC_CNT_MAX);

  // ==========================================================================
  // Divide by five
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_cnt_q <= 3'h0;
    else if (state_en)
    begin
      if (st_cnt_q == sbp_pkg::CYC_CNT_MAX)
        st_cnt_q <= 3'h0;
      else
        st_cnt_q <= st_cnt_q + 3'h1;
    end
  end

  assign state_idx = st_cnt_q;
  assign cycle_en = state_en && (st_cnt_q == sbp_pkg::CYC_CNT_MAX);

endmodule : sbp_timebase

//--- dv/sbp_bus_port_asserts.sv
// ==========================================
// Pin timing checker
module sbp_bus_port_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic cmd_ready,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic ram_req,
  input wire logic ram_grant,
  input wire logic instr_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_strobe_excl: assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  chk_wr_hold: assert property (!wr_n |-> !bus_oe_n && $stable(bus_out))
    else $error("write data not held under write strobe");
  chk_rd_float: assert property (!rd_n |-> bus_oe_n)
    else $error("bus driven during read strobe");
  chk_wr_width: assert property ($fell(wr_n) |=> !wr_n[*8] ##1 wr_n)
    else $error("write strobe width wrong");
  chk_rd_width: assert property ($fell(rd_n) |=> !rd_n[*8] ##1 rd_n)
    else $error("read strobe width wrong");
  chk_ale_period: assert property ($rose(ale) |=> ale[*2] ##1 !ale[*8] ##4 !ale ##1 (ale || !instr_run))
    else $error("machine cycle length wrong");
  chk_strobe_start: assert property ($fell(rd_n) || $fell(wr_n) |-> $past(ale) && !ale)
    else $error("strobe not started after address latch state");
  chk_busy_refuse: assert property (!rd_n || !wr_n |-> !cmd_ready)
    else $error("command accepted during strobe");
  chk_ram_guard: assert property (disable iff (1'b0) (rstn ? (ram_grant == ram_req) : !ram_grant))
    else $error("data memory grant wrong");
endmodule : sbp_bus_port_asserts
bind sbp_bus_port sbp_bus_port_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .cmd_ready(cmd_ready), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .rd_n(rd_n),
  .wr_n(wr_n), .ale(ale), .ram_req(ram_req), .ram_grant(ram_grant), .instr_run(instr_run));

//--- dv/sbp_ext_mem.sv
// ==========================================
// Far-side data memory model
module sbp_ext_mem (
  // Clock and mode
  input wire logic ref_clk,
  input wire logic slow,
  // Bus pins
  input wire logic [7:0] bus_out,
  input wire logic bus_oe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q = 8'h00;
  int wait_q = 0;
  always @(posedge ref_clk)
  begin
    if (!wr_n)
      mem_q <= bus_out;
    wait_q <= rd_n ? 0 : wait_q + 1;
  end
  // Unselected bus shows inverted data so a badly timed sample cannot match
  always_comb
  begin
    if (!bus_oe_n)
      bus_in = bus_out;
    else if (!rd_n && (!slow || wait_q >= 4))
      bus_in = mem_q;
    else
      bus_in = ~mem_q;
  end
endmodule : sbp_ext_mem

//--- dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic stall = 1'b1;
  logic slow = 1'b0;
  logic test_input_zero = 1'b0, test_input_one = 1'b0, ext_int_n = 1'b1;
  logic step_pause_n = 1'b1, ram_req = 1'b1;
  logic cmd_ready, rd_valid, bus_oe_n, rd_n, wr_n, ale, ram_grant, instr_run;
  logic test_zero_q, test_one_q, ext_int_n_q;
  sbp_pkg::sbp_cmd_t cmd_op = sbp_pkg::SBP_CMD_NONE;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] rd_data, bus_in, bus_out, v;
  logic [7:0] exp_q[$];
  logic take;
  int failures = 0, check_count = 0, cyc = 0;

  sbp_bus_port u_sbp_bus_port (.ref_clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_wdata, .rd_valid, .rd_ready, .rd_data, .bus_in, .bus_out, .bus_oe_n, .rd_n,
    .wr_n, .ale, .test_input_zero, .test_input_one, .ext_int_n, .test_zero_q,
    .test_one_q, .ext_int_n_q, .step_pause_n, .ram_req, .ram_grant, .instr_run);
  sbp_ext_mem u_sbp_ext_mem (.ref_clk, .slow, .bus_out, .bus_oe_n, .rd_n, .wr_n, .bus_in);

  // ==========================================
  // Clock, timeout, reader
  initial
    forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  // Read data only move on a rising edge, so what stands now is what the
  // next rising edge hands over when ready is offered
  always @(negedge ref_clk)
  begin
    take = !stall && 1'($urandom % 2);
    rd_ready <= take;
    ram_req <= 1'($urandom % 2);
    if (rstn && rd_valid === 1'b1 && take)
      chk(rd_data, exp_q.pop_front());
  end

  // ==========================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input sbp_pkg::sbp_cmd_t op, input logic [7:0] d);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1)
      @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : send
  task automatic drain();
    while (exp_q.size() != 0 || cmd_ready !== 1'b1)
      @(negedge ref_clk);
  endtask : drain
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // Tests
  initial
  begin
    void'($urandom(70));
    repeat (16) @(negedge ref_clk);
    chk({4'h0, rd_n, wr_n, bus_oe_n, ram_grant}, 8'h0E);
    rstn = 1'b1;
    $display("Test reset done");
    // Reads pile up behind a stalled reader; the last one answers slowly
    for (int i = 0; i < 3; i++)
    begin
      v = 8'($urandom);
      send(sbp_pkg::SBP_CMD_EXT_WR, v);
      slow = (i == 2);
      exp_q.push_back(v);
      send(sbp_pkg::SBP_CMD_EXT_RD, 8'h00);
    end
    // Third byte waits in the capture stage: command refused, bus released
    repeat (40) @(negedge ref_clk);
    chk({6'h0, cmd_ready, bus_oe_n}, 8'h01);
    stall = 1'b0;
    drain();
    $display("Test bidirectional done");
    v = 8'($urandom);
    send(sbp_pkg::SBP_CMD_LATCH_OUT, v);
    repeat (40) @(negedge ref_clk);
    chk(bus_out, v);
    chk({7'h0, bus_oe_n}, 8'h00);
    exp_q.push_back(v);
    send(sbp_pkg::SBP_CMD_STROBED_IN, 8'h00);
    drain();
    $display("Test static done");
    repeat (4)
    begin
      {test_input_zero, test_input_one, ext_int_n} = 3'($urandom);
      repeat (3) @(negedge ref_clk);
      chk({5'h0, test_zero_q, test_one_q, ext_int_n_q},
        {5'h0, test_input_zero, test_input_one, ext_int_n});
    end
    $display("Test test inputs done");
    step_pause_n = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk({6'h0, instr_run, cmd_ready}, 8'h00);
    step_pause_n = 1'b1;
    exp_q.push_back(v);
    send(sbp_pkg::SBP_CMD_EXT_RD, 8'h00);
    drain();
    $display("Test single step done");
    v = 8'($urandom);
    send(sbp_pkg::SBP_CMD_LATCH_OUT, v);
    repeat (40) @(negedge ref_clk);
    rstn = 1'b0;
    repeat (sbp_pkg::RST_MIN_CYC * sbp_pkg::OSC_DIV * sbp_pkg::CYC_DIV) @(negedge ref_clk);
    chk({4'h0, rd_n, wr_n, bus_oe_n, ram_grant}, 8'h0E);
    chk(bus_out, sbp_pkg::BUS_RST);
    rstn = 1'b1;
    exp_q.push_back(v);
    send(sbp_pkg::SBP_CMD_STROBED_IN, 8'h00);
    drain();
    $display("Test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb
